// ### cdr_pkg.sv
// Purpose: Shared constants and helpers for the identity and access-parameter records
// Assumes: 128-bit records, bit 0 of each record reads as one
// Notes: Programmable byte sits at record bits 15:8

package cdr_pkg;

   localparam int unsigned REC_W = 128;
   localparam int unsigned BODY_W = 120;
   localparam int unsigned PROG_LSB = 8;
   localparam int unsigned SERIAL_LSB = 16;
   localparam int unsigned REV_LSB = 48;

   // Identity record constant fields
   localparam logic [5:0] CID_RSVD = 6'h00;
   localparam logic [1:0] PKG_TYPE_SOLDERED = 2'h1;

   // Access-parameter record, read-only part; low 16 bits are filled at run time
   localparam logic [127:0] CSD_FIXED = {2'h3, 4'h4, 2'h0, 8'h27, 8'h01, 8'h32, 12'h0f5, 4'h9,
      1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 12'hfff, 3'h6, 3'h6, 3'h6, 3'h6, 3'h7, 5'h1f, 5'h1f,
      5'h0f, 1'h1, 2'h0, 3'h3, 4'h9, 1'h0, 4'h0, 1'h0, 16'h0001};

   // Bits compared against a program request; low 16 bits are never compared
   localparam logic [127:0] RO_CMP_MASK = {{112{1'b1}}, 16'h0000};

   // Programmable byte: 7 fmt_grp, 6 copy, 5 perm_prot, 4 tmp_prot, 3:2 fmt, 1:0 ecc
   localparam logic [7:0] PROG_RST = 8'h40;
   localparam logic [7:0] OTP_MASK = 8'hec;
   localparam logic [7:0] PROT_MASK = 8'h30;
   localparam logic [7:0] READ_MASK = 8'hff;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b01,
      ST_SETTLE = 2'b10
   } cdr_state_t;

   // CRC7, polynomial x^7 + x^3 + 1, msb first
   function automatic logic [6:0] crc7(input logic [119:0] d);
      logic [6:0] c;
      logic fb;
      c = 7'h00;
      for (int i = 119; i >= 0; i--)
      begin
         fb = d[i] ^ c[6];
         c = {c[5:0], 1'b0};
         if (fb)
         begin
            c = c ^ 7'h09;
         end
      end
      return c;
   endfunction

endpackage

// ### cdr_prog_if.sv
// Purpose: Carries program requests between the record bank and the field store
// Assumes: Single clock, requests valid for one cycle
// Notes: err is a one-cycle pulse one cycle after a refused request

`timescale 1ns/1ps

interface cdr_prog_if;
   logic prog_valid;
   logic [7:0] prog_byte;
   logic wp_allowed;
   logic [7:0] field_ff;
   logic err;

   modport bank
   (
      output prog_valid,
      output prog_byte,
      output wp_allowed,
      input field_ff,
      input err
   );

   modport store
   (
      input prog_valid,
      input prog_byte,
      input wp_allowed,
      output field_ff,
      output err
   );
endinterface

// ### cdr_crc7.sv
// Purpose: Registered CRC7 over a 120-bit record body
// Assumes: Body held stable for one cycle before use
// Notes: One cycle of latency after any body change

`timescale 1ns/1ps

module cdr_crc7
(
   input wire logic ref_clk,         // Clock
   input wire logic rst_b,           // Sync reset, active low
   input wire logic [119:0] body,    // Record body, msb first
   output logic [6:0] crc_ff         // Registered checksum
);

   typedef struct packed
   {
      logic [6:0] crc;
   } cdr_crc_t;

   cdr_crc_t st_ff;
   cdr_crc_t nxt_ff;

   always_comb
   begin
      nxt_ff = st_ff;
      nxt_ff.crc = cdr_pkg::crc7(body);
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_ff;
      end
   end

   assign crc_ff = st_ff.crc;

endmodule

// ### cdr_field_store.sv
// Purpose: Retained programmable byte of the access-parameter record
// Assumes: Cleared only by the factory init strobe, not by power-on or protocol reset
// Notes: A refused request changes nothing and pulses err

`timescale 1ns/1ps

module cdr_field_store
(
   input wire logic ref_clk,         // Clock
   input wire logic nv_init_b,       // Factory init, sync, active low
   cdr_prog_if.store pif             // Program requests from the bank
);

   typedef struct packed
   {
      logic [7:0] field;
      logic [7:0] done;
      logic err;
   } cdr_store_t;

   cdr_store_t st_ff;
   cdr_store_t nxt_ff;
   logic [7:0] chg;
   logic bad;

   always_comb
   begin
      nxt_ff = st_ff;
      nxt_ff.err = 1'b0;
      chg = pif.prog_byte ^ st_ff.field;
      // Each one-time bit takes one change only
      bad = ((chg & st_ff.done & cdr_pkg::OTP_MASK) != 8'h00) ||
            (((chg & cdr_pkg::PROT_MASK) != 8'h00) && !pif.wp_allowed);
      if (pif.prog_valid)
      begin
         if (bad)
         begin
            nxt_ff.err = 1'b1;
         end
         else
         begin
            // Only the programmable byte is ever written
            nxt_ff.field = pif.prog_byte;
            nxt_ff.done = st_ff.done | (chg & cdr_pkg::OTP_MASK);
         end
      end
   end

   // No power-on or protocol reset here: retained fields survive both
   always_ff @(posedge ref_clk)
   begin
      if (!nv_init_b)
      begin
         st_ff <= {cdr_pkg::PROG_RST, 8'h00, 1'b0};
      end
      else
      begin
         st_ff <= nxt_ff;
      end
   end

   assign pif.field_ff = st_ff.field;
   assign pif.err = st_ff.err;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nv_init_b);

   otp_hold_a: assert property ($past(nv_init_b) |->
      (((st_ff.field ^ $past(st_ff.field)) & $past(st_ff.done) & cdr_pkg::OTP_MASK) == 8'h00))
      else $error("one-time field changed twice");
   wp_hold_a: assert property (pif.prog_valid && !pif.wp_allowed |=>
      ((st_ff.field ^ $past(st_ff.field)) & cdr_pkg::PROT_MASK) == 8'h00)
      else $error("protection bit changed while locked");
   refuse_stable_a: assert property (pif.prog_valid && bad |=> st_ff.err && $stable(st_ff.field))
      else $error("refused program altered fields");

endmodule

// ### cdr_record_bank.sv
// Purpose: Identity and access-parameter records with program-request handling
// Assumes: Requests come from host-controller logic on ref_clk; nv_init_b pulsed once at start
// Notes: Requests are taken only while busy is low; program beats read in the same cycle
//
// Functional notes
// - Identity record is 128 bits, returned whole on request.
// - Identity record is answered in identification phase and afterwards alike.
// - Each unit gets its own serial and identity through parameters.
// - Serial is a 32-bit random number at bits 47:16.
// - Revision byte joins controller revision and firmware patch revision.
// - Application id, date and checksum follow the standard encodings.
// - Bit 0 of both records always reads one.
// - Program request changes only the programmable byte.
// - One-time bits take one programming each; READ_MASK is 0xff, so every bit reads back and none is write-only.
// - Readable one-time fields such as copy and permanent protect take one programming.
// - Retained writable fields survive power loss, hardware reset and protocol reset.
// - Volatile writable fields return to default on any reset.
// - Clear-then-write fields are writable only after power or hardware clearing.
// - Second access time reads 0x1, units of 100 clocks, bits 111:104.
// - First access time reads 0x27 at bits 119:112.
// - Max bus clock code reads 0x32 at bits 103:96.
// - Read block length code reads 0x9 at bits 83:80.
// - Write block length code reads 0x9 at bits 25:22.
// - Partial read bit 79 and partial write bit 21 read zero.
// - Protect group enable bit 31 reads one, group size 0xF.
// - Erase group size and multiplier read 0x1F each.
// - Protection bits update by program request only in legacy mode or in secure mode with secure_wp_mask set.

`timescale 1ns/1ps

module cdr_record_bank
#(
   parameter logic [7:0] MFR_ID = 8'h5a,           // Arbitrary value
   parameter logic [7:0] APP_ID = 8'h00,           // Application identifier
   parameter logic [47:0] PRODUCT_NAME = 48'h0,    // Product name
   parameter logic [3:0] CTRL_REV = 4'h1,          // Controller revision count
   parameter logic [3:0] FW_REV = 4'h0,            // Firmware patch revision count
   parameter logic [31:0] SERIAL = 32'h0000_0001,  // Per-unit random serial
   parameter logic [7:0] MFG_DATE = 8'h00          // Month and year code
)
(
   input wire logic ref_clk,           // Clock, 100 MHz
   input wire logic rst_b,             // Power-on or hardware reset, sync, active low
   input wire logic nv_init_b,         // Factory init of retained fields, active low
   input wire logic cmd0_rst,          // Protocol reset pulse
   input wire logic cid_req,           // Identity record request pulse
   input wire logic csd_req,           // Access record request pulse
   input wire logic prog_valid,        // Program request pulse
   input wire logic [127:0] prog_data, // Full record image to program
   input wire logic secure_wp_en,      // Secure protection mode selected
   input wire logic secure_wp_mask,    // Secure mode allows protection updates
   output logic rsp_valid,             // Record answer pulse
   output logic [127:0] rsp_data,      // Record answer, held until next answer or reset
   output logic prog_done,             // Program finished pulse
   output logic prog_error,            // Program refused, with prog_done
   output logic busy                   // Requests ignored while high
);

   typedef struct packed
   {
      cdr_pkg::cdr_state_t state;
      logic pend_prog;
      logic pend_err;
      logic rsp_valid;
      logic [127:0] rsp_data;
      logic prog_done;
      logic prog_error;
   } cdr_bank_t;

   localparam cdr_bank_t BANK_RST = '{state: cdr_pkg::ST_SETTLE, default: '0};

   cdr_bank_t st_ff;
   cdr_bank_t nxt_ff;
   cdr_prog_if pif();

   logic [119:0] cid_body;
   logic [119:0] csd_body;
   logic [6:0] cid_crc;
   logic [6:0] csd_crc;
   logic [127:0] cid_word;
   logic [127:0] csd_word;
   logic ro_ok;
   logic idle;
   logic take_prog;
   logic cid_take;
   logic csd_take;

   // Identity record body, msb downward
   assign cid_body = {MFR_ID, cdr_pkg::CID_RSVD, cdr_pkg::PKG_TYPE_SOLDERED, APP_ID,
                      PRODUCT_NAME, CTRL_REV, FW_REV, SERIAL, MFG_DATE};

   // Fixed slices plus readable programmable byte
   assign csd_body = {cdr_pkg::CSD_FIXED[127:16], pif.field_ff & cdr_pkg::READ_MASK};

   // Checksums follow the bodies by one cycle
   cdr_crc7 u_cid_crc
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .body(cid_body),
      .crc_ff(cid_crc)
   );

   cdr_crc7 u_csd_crc
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .body(csd_body),
      .crc_ff(csd_crc)
   );

   assign cid_word = {cid_body, cid_crc, 1'b1};
   assign csd_word = {csd_body, csd_crc, 1'b1};

   assign idle = (st_ff.state == cdr_pkg::ST_IDLE);
   assign take_prog = idle && prog_valid && !cmd0_rst;
   // Same taking terms as the read sequences, as plain signals for checks
   assign cid_take = idle && !prog_valid && !cmd0_rst && cid_req;
   assign csd_take = idle && !prog_valid && !cmd0_rst && !cid_req && csd_req;
   // Read-only part of the image must match
   assign ro_ok = ((prog_data ^ csd_word) & cdr_pkg::RO_CMP_MASK) == 128'h0;

   assign pif.prog_valid = take_prog && ro_ok;
   assign pif.prog_byte = prog_data[cdr_pkg::PROG_LSB +: 8];
   assign pif.wp_allowed = !secure_wp_en || secure_wp_mask;

   cdr_field_store u_store
   (
      .ref_clk(ref_clk),
      .nv_init_b(nv_init_b),
      .pif(pif.store)
   );

   always_comb
   begin
      nxt_ff = st_ff;
      nxt_ff.rsp_valid = 1'b0;
      nxt_ff.prog_done = 1'b0;
      nxt_ff.prog_error = 1'b0;
      unique case (st_ff.state)
         cdr_pkg::ST_IDLE:
         begin
            if (prog_valid)
            begin
               nxt_ff.state = cdr_pkg::ST_SETTLE;
               nxt_ff.pend_prog = 1'b1;
               nxt_ff.pend_err = !ro_ok;
            end
            else if (cid_req)
            begin
               // Served in any phase, identification included
               nxt_ff.rsp_valid = 1'b1;
               nxt_ff.rsp_data = cid_word;
            end
            else if (csd_req)
            begin
               nxt_ff.rsp_valid = 1'b1;
               nxt_ff.rsp_data = csd_word;
            end
         end
         cdr_pkg::ST_SETTLE:
         begin
            // Wait one cycle so the checksum reflects the new byte
            nxt_ff.state = cdr_pkg::ST_IDLE;
            nxt_ff.prog_done = st_ff.pend_prog;
            nxt_ff.prog_error = st_ff.pend_prog && (st_ff.pend_err || pif.err);
            nxt_ff.pend_prog = 1'b0;
            nxt_ff.pend_err = 1'b0;
         end
         default:
         begin
            nxt_ff.state = cdr_pkg::ST_IDLE;
         end
      endcase
      // Protocol reset reloads BANK_RST: answer and pending program flags clear, state goes to ST_SETTLE
      if (cmd0_rst)
      begin
         nxt_ff = BANK_RST;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         st_ff <= BANK_RST;
      end
      else
      begin
         st_ff <= nxt_ff;
      end
   end

   assign rsp_valid = st_ff.rsp_valid;
   assign rsp_data = st_ff.rsp_data;
   assign prog_done = st_ff.prog_done;
   assign prog_error = st_ff.prog_error;
   assign busy = st_ff.state[1];

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   sequence cid_take_s;
      idle && !prog_valid && !cmd0_rst && cid_req;
   endsequence

   sequence csd_take_s;
      idle && !prog_valid && !cmd0_rst && !cid_req && csd_req;
   endsequence

   cid_answer_a: assert property (cid_take_s |=> rsp_valid && rsp_data[127:8] == $past(cid_body))
      else $error("identity answer wrong or missing");
   serial_field_a: assert property (cid_take_s |=> rsp_data[47:16] == SERIAL)
      else $error("serial field misplaced");
   revision_field_a: assert property (cid_take_s |=> rsp_data[55:48] == {CTRL_REV, FW_REV})
      else $error("revision field wrong");
   cid_layout_a: assert property (cid_take_s |=>
      rsp_data[127:120] == MFR_ID && rsp_data[119:112] == 8'h01)
      else $error("identity upper fields wrong");
   bit0_one_a: assert property (rsp_valid |-> rsp_data[0])
      else $error("record bit 0 not one");
   crc_match_a: assert property (rsp_valid |-> rsp_data[7:1] == cdr_pkg::crc7(rsp_data[127:8]))
      else $error("record checksum mismatch");
   csd_fixed_a: assert property (csd_take_s |=>
      (rsp_data & cdr_pkg::RO_CMP_MASK) == (cdr_pkg::CSD_FIXED & cdr_pkg::RO_CMP_MASK))
      else $error("access record fixed part wrong");
   access_time_a: assert property (csd_take_s |=>
      rsp_data[119:112] == 8'h27 && rsp_data[111:104] == 8'h01 && rsp_data[103:96] == 8'h32)
      else $error("access time or clock code wrong");
   block_len_a: assert property (csd_take_s |=>
      rsp_data[83:80] == 4'h9 && rsp_data[25:22] == 4'h9 && !rsp_data[79] && !rsp_data[21])
      else $error("block length codes wrong");
   groups_a: assert property (csd_take_s |=> rsp_data[31] && rsp_data[36:32] == 5'h0f &&
      rsp_data[46:42] == 5'h1f && rsp_data[41:37] == 5'h1f)
      else $error("group fields wrong");
   prog_seq_a: assert property (take_prog |=> busy && !rsp_valid ##1 prog_done && !busy)
      else $error("program sequence wrong");
   ro_refuse_a: assert property (take_prog && !ro_ok |=> ##1 prog_done && prog_error)
      else $error("read-only mismatch not refused");
   wp_refuse_a: assert property (take_prog && ro_ok && !pif.wp_allowed &&
      ((prog_data[13:12] ^ pif.field_ff[5:4]) != 2'h0) |=> ##1 prog_error)
      else $error("locked protection change not refused");
   cmd0_clear_a: assert property (cmd0_rst |=> busy && !rsp_valid && !prog_done ##1 !busy)
      else $error("protocol reset did not clear answer state");

   // Answers and completions only follow a taken request
   answer_cause_a: assert property (rsp_valid |->
      $past(cid_take || csd_take))
      else $error("answer without a taken request");

   done_cause_a: assert property (prog_done |->
      $past(take_prog, 2))
      else $error("program completion without request");

   error_with_done_a: assert property (prog_error |->
      prog_done)
      else $error("program error without completion");

   busy_quiet_a: assert property (busy |=>
      !rsp_valid)
      else $error("request served while busy");

   rsp_hold_a: assert property (!cid_take && !csd_take && !cmd0_rst |=>
      $stable(rsp_data))
      else $error("answer data changed without a request");

   // Programmable byte reads back as stored
   csd_byte_a: assert property (csd_take |=>
      rsp_data[15:8] == $past(pif.field_ff))
      else $error("programmable byte not read back");

   app_date_a: assert property (cid_take |=>
      rsp_data[111:104] == APP_ID && rsp_data[15:8] == MFG_DATE)
      else $error("application id or date wrong");

   name_field_a: assert property (cid_take |=>
      rsp_data[103:56] == PRODUCT_NAME)
      else $error("product name misplaced");

   // Stored byte moves only on an accepted request
   store_quiet_a: assert property (!pif.prog_valid && nv_init_b |=>
      $stable(pif.field_ff))
      else $error("programmable byte changed without request");

   cmd0_keep_a: assert property (cmd0_rst |=>
      $stable(pif.field_ff))
      else $error("protocol reset altered retained byte");

   // Checksum register trails the body by one edge, not across reset
   crc_follow_a: assert property ($past(rst_b) |->
      csd_crc == cdr_pkg::crc7($past(csd_body)))
      else $error("access checksum stale");

   cid_seen_c: cover property (cid_take_s ##1 rsp_valid);
   csd_seen_c: cover property (csd_take_s ##1 rsp_valid);
   prog_ok_c: cover property (take_prog ##2 (prog_done && !prog_error));
   prog_bad_c: cover property (take_prog ##2 (prog_done && prog_error));
   cmd0_seen_c: cover property (cmd0_rst ##2 !busy);

endmodule

// ### cdr_host_model.sv
// Purpose: Host-controller model issuing record reads, program requests and protocol resets
// Assumes: Tasks are entered just after a rising edge of ref_clk
// Notes: Program data is inverted once released so stale values never look valid

`timescale 1ns/1ps

module cdr_host_model
(
   input wire logic ref_clk,           // Clock
   input wire logic busy,              // Device not taking requests
   input wire logic rsp_valid,         // Record answer pulse
   input wire logic [127:0] rsp_data,  // Record answer
   input wire logic prog_done,         // Program finished pulse
   input wire logic prog_error,        // Program refused
   output logic cmd0_rst,              // Protocol reset pulse
   output logic cid_req,               // Identity request pulse
   output logic csd_req,               // Access record request pulse
   output logic prog_valid,            // Program request pulse
   output logic [127:0] prog_data,     // Program image
   output logic secure_wp_en,          // Secure protection mode
   output logic secure_wp_mask         // Secure mode allows protection updates
);
   initial
   begin
      cmd0_rst = 1'b0;
      cid_req = 1'b0;
      csd_req = 1'b0;
      prog_valid = 1'b0;
      prog_data = 128'h0;
      secure_wp_en = 1'b0;
      secure_wp_mask = 1'b0;
   end

   task automatic wait_idle(output bit ok);
      ok = 1'b0;
      for (int n = 0; n < 8; n++)
      begin
         if (busy === 1'b0)
         begin
            ok = 1'b1;
            break;
         end
         @(posedge ref_clk);
         #1;
      end
   endtask

   task automatic read_rec(input bit ident, output logic [127:0] data, output bit ok);
      wait_idle(ok);
      if (ok)
      begin
         cid_req = ident;
         csd_req = !ident;
         @(posedge ref_clk);
         #1;
         cid_req = 1'b0;
         csd_req = 1'b0;
         ok = 1'b0;
         for (int n = 0; n < 4; n++)
         begin
            if (rsp_valid === 1'b1)
            begin
               ok = 1'b1;
               data = rsp_data;
               break;
            end
            @(posedge ref_clk);
            #1;
         end
      end
   endtask

   // Only path that alters the access record
   task automatic prog_rec(input logic [127:0] img, output logic err, output bit ok);
      wait_idle(ok);
      if (ok)
      begin
         prog_valid = 1'b1;
         prog_data = img;
         @(posedge ref_clk);
         #1;
         prog_valid = 1'b0;
         prog_data = ~img;
         ok = 1'b0;
         for (int n = 0; n < 4; n++)
         begin
            if (prog_done === 1'b1)
            begin
               ok = 1'b1;
               err = prog_error;
               break;
            end
            @(posedge ref_clk);
            #1;
         end
      end
   endtask

   task automatic proto_reset();
      cmd0_rst = 1'b1;
      @(posedge ref_clk);
      #1;
      cmd0_rst = 1'b0;
   endtask

   task automatic set_mode(input logic en, input logic mask);
      secure_wp_en = en;
      secure_wp_mask = mask;
   endtask
endmodule

// ### cdr_record_bank_tb_top.sv
// Purpose: Self-checking bench for the record bank through the host model
// Assumes: Identity fields set to distinct per-unit values below
// Notes: Expected records are built here from the field layout

`timescale 1ns/1ps

module cdr_record_bank_tb_top;
   localparam logic [7:0] MFR = 8'h3c;        // Arbitrary value
   localparam logic [7:0] APP = 8'h21;
   localparam logic [47:0] NAME = 48'h616263646566;
   localparam logic [3:0] CREV = 4'h2;
   localparam logic [3:0] FREV = 4'h7;
   localparam logic [31:0] SER = 32'ha5c3_0f96;
   localparam logic [7:0] DATE = 8'h9b;

   logic ref_clk, rst_b, nv_init_b, cmd0_rst, cid_req, csd_req, prog_valid;
   logic secure_wp_en, secure_wp_mask, rsp_valid, prog_done, prog_error, busy;
   logic [127:0] prog_data, rsp_data, got;
   logic [7:0] cur;
   logic err;
   bit ok;
   int miscompares, compares;

   cdr_record_bank #(.MFR_ID(MFR), .APP_ID(APP), .PRODUCT_NAME(NAME), .CTRL_REV(CREV), .FW_REV(FREV),
      .SERIAL(SER), .MFG_DATE(DATE)) cdr_record_bank_i (.ref_clk(ref_clk), .rst_b(rst_b),
      .nv_init_b(nv_init_b), .cmd0_rst(cmd0_rst), .cid_req(cid_req), .csd_req(csd_req),
      .prog_valid(prog_valid), .prog_data(prog_data), .secure_wp_en(secure_wp_en),
      .secure_wp_mask(secure_wp_mask), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .prog_done(prog_done), .prog_error(prog_error), .busy(busy));

   cdr_host_model cdr_host_model_i (.ref_clk(ref_clk), .busy(busy), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .prog_done(prog_done), .prog_error(prog_error), .cmd0_rst(cmd0_rst),
      .cid_req(cid_req), .csd_req(csd_req), .prog_valid(prog_valid), .prog_data(prog_data),
      .secure_wp_en(secure_wp_en), .secure_wp_mask(secure_wp_mask));

   function automatic logic [127:0] seal(input logic [119:0] d);
      logic [6:0] r;
      r = 7'h00;
      for (int i = 119; i >= 0; i--)
      begin
         r = {r[5:0], 1'b0} ^ (((d[i] ^ r[6]) == 1'b1) ? 7'h09 : 7'h00);
      end
      return {d, r, 1'b1};
   endfunction

   function automatic logic [127:0] exp_ident();
      return seal({MFR, 6'h00, 2'h1, APP, NAME, CREV, FREV, SER, DATE});
   endfunction

   function automatic logic [127:0] exp_access(input logic [7:0] pb);
      return seal({2'h3, 4'h4, 2'h0, 8'h27, 8'h01, 8'h32, 12'h0f5, 4'h9, 4'h0, 2'h0, 12'hfff,
         3'h6, 3'h6, 3'h6, 3'h6, 3'h7, 5'h1f, 5'h1f, 5'h0f, 1'h1, 2'h0, 3'h3, 4'h9, 1'h0, 4'h0, 1'h0, pb});
   endfunction

   task automatic tally_and_finish();
      if (miscompares == 0 && compares > 0)
      begin
         $display("Test passed");
      end
      else
      begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input logic [127:0] g, input logic [127:0] e, input string what);
      compares++;
      if (g !== e)
      begin
         miscompares++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
      end
   endtask

   task automatic need(input bit good);
      if (!good)
      begin
         miscompares++;
         $display("mismatch at %0t: no answer within bound", $time);
         tally_and_finish();
      end
   endtask

   task automatic rd(input bit ident, input logic [127:0] e);
      cdr_host_model_i.read_rec(ident, got, ok);
      need(ok);
      check(got, e, "record read");
   endtask

   // Program a byte, optionally disturbing read-only bits, then read back
   task automatic pg(input logic [7:0] pb, input logic [127:0] flip, input logic e_err);
      logic [127:0] img;
      img = exp_access(pb) ^ flip;
      img[7:0] = 8'h5e;
      cdr_host_model_i.prog_rec(img, err, ok);
      need(ok);
      check({127'h0, err}, {127'h0, e_err}, "program status");
      if (e_err === 1'b0)
      begin
         cur = pb;
      end
      rd(1'b0, exp_access(cur));
   endtask

   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   initial
   begin
      miscompares = 0;
      compares = 0;
      cur = 8'h40;
      rst_b = 1'b0;
      nv_init_b = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      rst_b = 1'b1;
      nv_init_b = 1'b1;
      rd(1'b1, exp_ident());
      rd(1'b0, exp_access(8'h40));
      rd(1'b1, exp_ident());
      pg(8'h50, 128'h0, 1'b0);
      pg(8'h40, 128'h0, 1'b0);
      pg(8'h43, 128'h0, 1'b0);
      pg(8'h41, 128'h1 << 119, 1'b1);
      pg(8'h41, 128'h1 << 20, 1'b1);
      cdr_host_model_i.set_mode(1'b1, 1'b0);
      pg(8'h51, 128'h0, 1'b1);
      cdr_host_model_i.set_mode(1'b1, 1'b1);
      pg(8'h51, 128'h0, 1'b0);
      cdr_host_model_i.set_mode(1'b0, 1'b0);
      pg(8'h71, 128'h0, 1'b0);
      pg(8'h51, 128'h0, 1'b1);
      pg(8'h31, 128'h0, 1'b0);
      pg(8'h71, 128'h0, 1'b1);
      pg(8'hb1, 128'h0, 1'b0);
      pg(8'hb5, 128'h0, 1'b0);
      pg(8'hb9, 128'h0, 1'b1);
      rst_b = 1'b0;
      @(posedge ref_clk);
      #1;
      check(rsp_data, 128'h0, "answer cleared in reset");
      check({127'h0, busy}, {127'h0, 1'b1}, "busy in reset");
      rst_b = 1'b1;
      rd(1'b0, exp_access(cur));
      cdr_host_model_i.proto_reset();
      rd(1'b0, exp_access(cur));
      rd(1'b1, exp_ident());
      tally_and_finish();
   end
endmodule
